// File: hdl/tx_align_params.svh
// offsets, field positions, reset values and timing counts of the transmit input path
// assumes one 20 MHz system clock that also stands for the reference clock
`ifndef TX_ALIGN_PARAMS_SVH
`define TX_ALIGN_PARAMS_SVH

`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_PERR_CNT 12'h008

`define CTRL_CAP_EN_BIT 0
`define CTRL_RESYNC_BIT 1
`define CTRL_RESET 32'h0000_0001

`define ST_ERR_BIT 0
`define ST_INIT_BIT 1
`define ST_DIRECT_BIT 2
`define ST_OCC_LSB 4

`define CLK_PERIOD_NS 50
`define CHAR_PERIOD_NS 400
`define CHAR_CYCLES (`CHAR_PERIOD_NS / `CLK_PERIOD_NS)
`define RST_LOW_SAMPLES 2'h2

`define C07_POS 10'h278
`define CT_SYNC 2'h3

`define LVL_CODE_LOW 2'h0
`define LVL_CODE_MID 2'h1
`define LVL_CODE_HIGH 2'h2

`endif

// File: hdl/tx_align_pkg.sv
// types shared by the transmit input path and its bench
// assumes the constants of tx_align_params.svh
package tx_align_pkg;

  typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_t;

  typedef enum logic [2:0] {
    KIND_PRE, KIND_DATA, KIND_SPECIAL, KIND_C07, KIND_K28_5, KIND_SYNC
  } char_kind_t;

  typedef struct packed {
    logic [7:0] data;
    logic [1:0] ct;
    logic special_code_select;
    logic op;
  } tx_in_t;

  typedef struct packed {
    char_kind_t kind;
    logic enc_en;
    logic [9:0] chr;
  } tx_sel_t;

endpackage

// File: hdl/tx_input_align.sv
// transmit input register, phase-align buffer, odd parity check and character selection
// assumes pins arrive asynchronously; enc_char_i and APB come from logic on clk_sys_i
`timescale 1ns/1ps
`include "tx_align_params.svh"

module tx_input_align
  import tx_align_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int CHAR_CYC = `CHAR_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] tx_data_i,
  input wire logic [1:0] tx_char_control_i,
  input wire logic special_code_select_i,
  input wire logic tx_parity_bit_i,
  input wire logic [1:0] tx_mode_upper_i,
  input wire logic [1:0] tx_mode_lower_i,
  input wire logic [1:0] input_clock_select_i,
  input wire logic [1:0] parity_check_control_i,
  input wire logic dual_edge_rate_select_i,
  input wire logic host_input_clock_i,
  input wire logic tx_path_reset_n_i,
  input wire logic [9:0] enc_char_i,
  output tx_sel_t sel_o,
  output logic sel_valid_o,
  output logic [4:0] tx_serial_o,
  output logic tx_serial_valid_o,
  output logic tx_error_flag_o,
  output logic parity_err_o
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CENTER = (PW + 1)'(DEPTH / 2);
  localparam logic [3:0] DIV_FULL = 4'(CHAR_CYC - 1);
  localparam logic [3:0] DIV_HALF = 4'(CHAR_CYC / 2 - 1);
  localparam int PINS = 23;

  generate
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || CHAR_CYC < 4 || CHAR_CYC > 16) begin : g_chk
      $error("tx_input_align: DEPTH must be a power of two >= 4, CHAR_CYC in 4..16");
    end
  endgenerate

  function automatic level_t decode_level(input logic [1:0] code);
    unique case (code)
      `LVL_CODE_LOW: decode_level = LVL_LOW;
      `LVL_CODE_HIGH: decode_level = LVL_HIGH;
      // an open pin, and the unused code, read as the middle level
      default: decode_level = LVL_MID;
    endcase
  endfunction

  function automatic logic parity_fail(input tx_in_t c, input level_t p, input logic enc);
    logic ok;
    ok = 1'b1;
    if (p == LVL_MID && enc) begin
      ok = ^{c.data, c.op};
    end else if (p != LVL_LOW) begin
      ok = ^{c.data, c.ct, c.op};
    end
    parity_fail = (p != LVL_LOW) && !ok;
  endfunction

  function automatic char_kind_t pick_kind(input tx_in_t c, input logic enc, input level_t lo);
    char_kind_t k;
    k = KIND_K28_5;
    if (!enc) begin
      k = KIND_PRE;
    end else if (!c.ct[0]) begin
      k = KIND_DATA;
    end else if (c.ct[1]) begin
      k = KIND_SYNC;
    end else if (c.special_code_select && lo == LVL_LOW) begin
      k = KIND_SPECIAL;
    end else if (c.special_code_select && lo == LVL_MID) begin
      k = KIND_SYNC;
    end
    pick_kind = k;
  endfunction

  // pin synchroniser: every asynchronous input passes two flops
  logic [PINS-1:0] pin_s1_r;
  logic [PINS-1:0] pin_s2_r;
  logic hclk_prev_r;
  wire logic [PINS-1:0] pin_raw = {tx_data_i, tx_char_control_i, special_code_select_i,
    tx_parity_bit_i, tx_mode_upper_i, tx_mode_lower_i, input_clock_select_i,
    parity_check_control_i, dual_edge_rate_select_i, host_input_clock_i, tx_path_reset_n_i};

  always_ff @(posedge clk_sys_i) begin
    pin_s1_r <= pin_raw;
    pin_s2_r <= pin_s1_r;
    hclk_prev_r <= pin_s2_r[1];
  end

  wire logic [7:0] data_s = pin_s2_r[22:15];
  wire logic [1:0] ct_s = pin_s2_r[14:13];
  wire logic special_code_select_s = pin_s2_r[12];
  wire logic op_s = pin_s2_r[11];
  wire logic rate_s = pin_s2_r[2];
  wire logic hclk_s = pin_s2_r[1];
  wire logic rst_n_s = pin_s2_r[0];

  wire level_t mode_up = decode_level(pin_s2_r[10:9]);
  wire level_t mode_lo = decode_level(pin_s2_r[8:7]);
  wire level_t ick = decode_level(pin_s2_r[6:5]);
  wire level_t par = decode_level(pin_s2_r[4:3]);

  wire logic enc_en = mode_up != LVL_LOW;
  wire logic direct = (ick == LVL_LOW) && !rate_s;
  wire logic special_code_select_used = mode_lo != LVL_HIGH;
  wire tx_in_t in_now = '{data: data_s, ct: ct_s, special_code_select: special_code_select_s & special_code_select_used, op: op_s};

  // APB control and status
  logic [31:0] ctrl_r;
  logic [15:0] perr_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  wire logic apb_setup = psel_i && !penable_i;
  wire logic apb_done = psel_i && penable_i && pready_r;
  wire logic apb_wr = apb_done && pwrite_i;
  wire logic hit_ctrl = paddr_i == `OFS_CTRL;
  wire logic hit_status = paddr_i == `OFS_STATUS;
  wire logic hit_perr = paddr_i == `OFS_PERR_CNT;
  wire logic apb_hit = hit_ctrl || hit_status || hit_perr;
  wire logic cap_en = ctrl_r[`CTRL_CAP_EN_BIT];
  wire logic resync = apb_wr && hit_ctrl && pwdata_i[`CTRL_RESYNC_BIT];

  // phase-align buffer and reset sequencing
  logic [1:0] rst_low_cnt_r;
  logic init_r;
  logic err_r;
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  tx_in_t buf_r [DEPTH];
  logic [3:0] div_r;

  wire logic [1:0] rst_low_cnt_nxt = rst_n_s ? 2'h0 :
    (rst_low_cnt_r == `RST_LOW_SAMPLES) ? rst_low_cnt_r : rst_low_cnt_r + 2'h1;
  wire logic init_enter = (rst_low_cnt_nxt == `RST_LOW_SAMPLES) || resync;
  wire logic init_leave = init_r && rst_n_s && !resync;
  wire logic init_nxt = init_enter || (init_r && !init_leave);

  wire logic [3:0] div_last = rate_s ? DIV_HALF : DIV_FULL;
  wire logic char_en = div_r >= div_last;
  wire logic hclk_rise = hclk_s && !hclk_prev_r;
  wire logic hclk_fall = !hclk_s && hclk_prev_r;
  wire logic wr_stb = !direct && !init_r && cap_en && (hclk_rise || (rate_s && hclk_fall));
  wire logic rd_stb = char_en && !direct && !init_r;
  wire logic [PW:0] occ = wr_ptr_r - rd_ptr_r;
  wire logic full = occ == (PW + 1)'(DEPTH);
  wire logic empty = occ == '0;
  wire logic overflow = wr_stb && full && !rd_stb;
  wire logic underflow = rd_stb && empty;
  wire tx_in_t head = buf_r[rd_ptr_r[PW-1:0]];
  wire tx_in_t cur = direct ? in_now : head;
  wire logic recenter = err_r && rd_stb && mode_up == LVL_MID && cur.ct == `CT_SYNC;
  // a fresh overflow or underflow in the clearing cycle wins over the recenter clear
  wire logic err_set = overflow || underflow;
  wire logic err_nxt = init_r ? 1'b0 : err_set ? 1'b1 :
    recenter ? 1'b0 : err_r;
  wire logic [PW:0] realign_ptr = wr_ptr_r - CENTER;
  wire logic [PW:0] rd_ptr_nxt = (init_leave || recenter) ? realign_ptr :
    rd_stb ? rd_ptr_r + (PW + 1)'(1) : rd_ptr_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_low_cnt_r <= 2'h0;
      init_r <= 1'b1;
      err_r <= 1'b0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      div_r <= 4'h0;
    end else begin
      rst_low_cnt_r <= rst_low_cnt_nxt;
      init_r <= init_nxt;
      err_r <= err_nxt;
      wr_ptr_r <= wr_stb ? wr_ptr_r + (PW + 1)'(1) : wr_ptr_r;
      rd_ptr_r <= rd_ptr_nxt;
      div_r <= char_en ? 4'h0 : div_r + 4'h1;
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_buf
      always_ff @(posedge clk_sys_i) begin
        if (wr_stb && wr_ptr_r[PW-1:0] == PW'(i)) begin
          buf_r[i] <= in_now;
        end
      end
    end
  endgenerate

  // character selection ahead of the encoder
  wire logic char_go = char_en && (direct || !init_r) && cap_en;
  wire logic perr = parity_fail(cur, par, enc_en);
  // a stale phase error wins over parity: the link must show the buffer fault
  wire logic sub_c07 = err_r || perr;
  wire char_kind_t kind_sel = sub_c07 ? KIND_C07 : pick_kind(cur, enc_en, mode_lo);
  wire logic [9:0] chr_sel = (sub_c07 && !enc_en) ? `C07_POS : {cur.ct, cur.data};
  wire logic [15:0] perr_cnt_inc = (char_go && perr) ? perr_cnt_r + 16'h1 : perr_cnt_r;
  wire logic perr_clr = apb_wr && hit_perr;

  tx_sel_t sel_r;
  logic sel_valid_r;
  logic perr_pulse_r;
  logic err_flag_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sel_r <= '{kind: KIND_PRE, enc_en: 1'b0, chr: 10'h000};
      sel_valid_r <= 1'b0;
      perr_pulse_r <= 1'b0;
      err_flag_r <= 1'b0;
    end else begin
      if (char_go) begin
        sel_r <= '{kind: kind_sel, enc_en: enc_en, chr: chr_sel};
      end
      sel_valid_r <= char_go;
      perr_pulse_r <= char_go && perr;
      err_flag_r <= err_nxt;
    end
  end

  // shifter: two 5-bit lanes per character, low half first; bypassed characters pass as is
  logic [4:0] ser_r;
  logic [4:0] ser_hold_r;
  logic ser_valid_r;
  logic ser_second_r;
  wire logic [9:0] ser_src = sel_r.enc_en ? enc_char_i : sel_r.chr;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ser_r <= 5'h00;
      ser_hold_r <= 5'h00;
      ser_valid_r <= 1'b0;
      ser_second_r <= 1'b0;
    end else if (sel_valid_r) begin
      ser_r <= ser_src[4:0];
      ser_hold_r <= ser_src[9:5];
      ser_valid_r <= 1'b1;
      ser_second_r <= 1'b1;
    end else begin
      ser_r <= ser_hold_r;
      ser_valid_r <= ser_second_r;
      ser_second_r <= 1'b0;
    end
  end

  // APB slave: no wait states, read data latched in the setup cycle
  wire logic [31:0] status_word = {{(32 - `ST_OCC_LSB - PW - 1){1'b0}}, occ, 1'b0,
    direct, init_r, err_r};
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_r : hit_status ? status_word :
    hit_perr ? {16'h0000, perr_cnt_r} : 32'h0000_0000;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
      perr_cnt_r <= 16'h0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && !apb_hit;
      if (apb_setup) begin
        prdata_r <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= {31'h0000_0000, pwdata_i[`CTRL_CAP_EN_BIT]};
      end
      // a parity event in the clearing cycle is kept as a count of one
      if (perr_clr) begin
        perr_cnt_r <= (char_go && perr) ? 16'h0001 : 16'h0000;
      end else begin
        perr_cnt_r <= perr_cnt_inc;
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign sel_o = sel_r;
  assign sel_valid_o = sel_valid_r;
  assign tx_serial_o = ser_r;
  assign tx_serial_valid_o = ser_valid_r;
  assign tx_error_flag_o = err_flag_r;
  assign parity_err_o = perr_pulse_r;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_reset_two_low;
    !rst_n_s ##1 !rst_n_s;
  endsequence

  sequence s_char_loaded;
    sel_valid_r ##1 ser_valid_r;
  endsequence

  a_reset_init_entry: assert property (s_reset_two_low |=> init_r)
    else $error("buffer not initialized after two low reset samples");

  a_direct_no_write: assert property (direct |-> !wr_stb)
    else $error("phase buffer written in direct mode");

  a_err_sticky: assert property (err_r && !init_r && !recenter |=> err_r)
    else $error("phase error dropped without reset or recenter");

  a_err_flag_out: assert property (err_set && !init_r |=> tx_error_flag_o)
    else $error("overflow not reported on error flag");

  a_err_sends_c07: assert property (char_go && err_r |=> sel_valid_o && sel_o.kind == KIND_C07)
    else $error("phase error without C0.7 substitution");

  a_recenter_clear: assert property (recenter && !err_set
    |=> !err_r && !tx_error_flag_o)
    else $error("recentering did not clear the error");

  a_bypass_c07: assert property (char_go && !enc_en && perr |=> sel_o.chr == 10'h278)
    else $error("bypass parity error pattern wrong");

  a_parity_subst: assert property (char_go && perr
    |=> parity_err_o && sel_o.kind == KIND_C07)
    else $error("parity error without pulse or C0.7 substitution");

  a_parity_off: assert property (char_go && par == LVL_LOW && !err_r |=> sel_o.kind != KIND_C07)
    else $error("substitution with parity disabled");

  a_mid_data_only: assert property (char_go && enc_en && par == LVL_MID && !err_r
    && ^{cur.data, cur.op} |=> sel_o.kind != KIND_C07)
    else $error("control bits took part in MID parity");

  a_lsb_first: assert property (s_char_loaded |-> tx_serial_o == $past(ser_src[4:0])
    ##1 ser_valid_r == 1'b1)
    else $error("low half of character not shifted first");

endmodule // tx_input_align

// File: test/tx_host_model.sv
// host side of the transmit input path: input clock and character pins
// assumes the bench gives the wanted character and a run level per frame
`timescale 1ns/1ps
module tx_host_model
  import tx_align_pkg::*;
(
  input wire logic run_i,
  input wire tx_in_t want_i,
  output logic host_clk_o,
  output tx_in_t pins_o
);
  // odd start offset keeps the host clock unrelated in phase to the system clock
  initial begin
    host_clk_o = 1'b0;
    #137;
    forever begin
      #200;
      if (run_i) begin
        host_clk_o = ~host_clk_o;
      end else begin
        host_clk_o = 1'b0;
      end
    end
  end
  initial pins_o = '0;
  // pins move only while the clock is low or run_i is low, so a rising edge never sees them change
  always @(negedge host_clk_o or want_i or run_i) begin
    if (!run_i || !host_clk_o) begin
      pins_o <= want_i;
    end
  end
endmodule // tx_host_model

// File: test/tx_input_align_tb.sv
// self-checking bench of the transmit input path with a host pin model
// assumes tx_input_align and tx_host_model; registers read over APB
`timescale 1ns/1ps
module tx_input_align_tb;
  import tx_align_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0, trn = 1'b1, rate = 1'b0;
  logic pready, pslverr, selv, serv, eflag, perr, hclk, p;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [32:0] rd;
  logic [1:0] up = 2'h0, lo = 2'h0, ics = 2'h0, pc = 2'h0;
  logic [9:0] encc = 10'h000;
  logic [4:0] ser;
  logic [15:0] lfsr = 16'hC80B;
  tx_in_t want = '0, pins;
  tx_sel_t sel, s;
  int fail_count = 0;
  int n_tests = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  tx_host_model i_tx_host_model (.run_i(run), .want_i(want), .host_clk_o(hclk), .pins_o(pins));
  tx_input_align i_tx_input_align (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_data_i(pins.data), .tx_char_control_i(pins.ct),
    .special_code_select_i(pins.special_code_select), .tx_parity_bit_i(pins.op), .tx_mode_upper_i(up),
    .tx_mode_lower_i(lo), .input_clock_select_i(ics), .parity_check_control_i(pc),
    .dual_edge_rate_select_i(rate), .host_input_clock_i(hclk), .tx_path_reset_n_i(trn),
    .enc_char_i(encc), .sel_o(sel), .sel_valid_o(selv), .tx_serial_o(ser),
    .tx_serial_valid_o(serv), .tx_error_flag_o(eflag), .parity_err_o(perr));

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic tx_sel_t expect_sel(input tx_in_t c, output logic pe);
    logic enc;
    logic odd;
    tx_sel_t e;
    enc = (up != 2'h0);
    odd = (pc == 2'h1 && enc) ? ^{c.data, c.op} : ^{c.data, c.ct, c.op};
    pe = (pc != 2'h0) && !odd;
    e.enc_en = enc;
    e.chr = {c.ct, c.data};
    if (!enc) e.kind = KIND_PRE;
    else if (!c.ct[0]) e.kind = KIND_DATA;
    else if (c.ct[1]) e.kind = KIND_SYNC;
    else if (c.special_code_select && lo == 2'h0) e.kind = KIND_SPECIAL;
    else if (c.special_code_select && lo == 2'h1) e.kind = KIND_SYNC;
    else e.kind = KIND_K28_5;
    if (pe) e.kind = KIND_C07;
    if (pe && !enc) e.chr = 10'h278;
    return e;
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rd = {pslverr, prdata};
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic next_char(output tx_sel_t sc, output logic pe);
    int n = 0;
    logic [5:0] lane0;
    logic [9:0] lane_src;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (selv !== 1'b1 && n < 100);
    if (selv !== 1'b1) fail_count++;
    sc = sel;
    // encoded characters reach the shifter from the external encoder, bypassed ones as selected
    lane_src = sc.enc_en ? encc : sc.chr;
    pe = perr;
    @(posedge clk_sys_i);
    lane0 = {serv, ser};
    @(posedge clk_sys_i);
    check({serv, ser, lane0}, {1'b1, lane_src[9:5], 1'b1, lane_src[4:0]});
  endtask

  // early characters may still carry the previous pins, so only the last is judged
  task automatic try_char(input tx_in_t c, input int k);
    tx_sel_t sc;
    tx_sel_t e;
    logic pg;
    logic ep;
    want <= c;
    repeat (k) next_char(sc, pg);
    e = expect_sel(c, ep);
    check(sc, e);
    check(pg, ep);
  endtask

  task automatic wait_flag(input logic v);
    int n = 0;
    while (eflag !== v && n < 600) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (eflag !== v) fail_count++;
  endtask

  initial begin
    fork
      begin
        #(20000 * 50);
        fail_count++;
        tally_and_finish();
      end
    join_none
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 33'h0_0000_0001);
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 33'h1_0000_0000);
    repeat (10) @(posedge clk_sys_i);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[2:0], 3'h4);
    $display("done: registers");
    for (int i = 0; i < 54; i++) begin
      lfsr = nx(lfsr);
      up <= 2'(i / 18);
      lo <= 2'(i / 6 % 3);
      pc <= 2'(i / 2 % 3);
      encc <= lfsr[15:6];
      try_char(tx_in_t'(lfsr[11:0]), 3);
    end
    $display("done: nine modes, three parity settings");
    pc <= 2'h0;
    repeat (4) @(posedge clk_sys_i);
    apb(1'b1, 12'h008, 32'h0);
    try_char(12'h000, 2);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 33'h0);
    ics <= 2'h1;
    run <= 1'b1;
    trn <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[1:0], 2'h2);
    trn <= 1'b1;
    try_char(12'h0A5, 6);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[2:0], 3'h0);
    run <= 1'b0;
    up <= 2'h0;
    wait_flag(1'b1);
    check(eflag, 1'b1);
    next_char(s, p);
    check(s, {KIND_C07, 1'b0, 10'h278});
    run <= 1'b1;
    repeat (100) @(posedge clk_sys_i);
    check(eflag, 1'b1);
    up <= 2'h1;
    want <= 12'h00C;
    wait_flag(1'b0);
    check(eflag, 1'b0);
    repeat (16) next_char(s, p);
    check(s.kind, KIND_SYNC);
    run <= 1'b0;
    wait_flag(1'b1);
    run <= 1'b1;
    trn <= 1'b0;
    up <= 2'h0;
    repeat (6) @(posedge clk_sys_i);
    trn <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    check(eflag, 1'b0);
    try_char(12'h3C6, 6);
    check(eflag, 1'b0);
    $display("done: phase-align buffer");
    ics <= 2'h0;
    rate <= 1'b1;
    trn <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    trn <= 1'b1;
    try_char(12'h5A1, 6);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[2:0], 3'h0);
    check(eflag, 1'b0);
    $display("done: dual-edge rate");
    tally_and_finish();
  end
endmodule // tx_input_align_tb
